// >>> inc/ahp_cfg.svh
/*
 * constants of the host port: widths, reset values, decode and timing.
 * assumes inclusion by bare name from the package and the host port rtl.
 */
`ifndef AHP_CFG_SVH
`define AHP_CFG_SVH

// -----------------------------------------------------------------------
// widths
// -----------------------------------------------------------------------
`define AHP_ADDR_W      5
`define AHP_WORD_W      4
`define AHP_DATA_W      16
`define AHP_BYTE_W      8
`define AHP_INT_N       8
`define AHP_CNT_W       6
`define AHP_CHAN_N      8
`define AHP_CHAN_W      3
`define AHP_PIN_W       27

// -----------------------------------------------------------------------
// clock limits in khz, and the running clock period in ns
// -----------------------------------------------------------------------
`define AHP_CLK_MIN_KHZ 50
`define AHP_CLK_MAX_KHZ 10000
`define AHP_CLK_PER_NS  40

// -----------------------------------------------------------------------
// decode, lanes and reset values
// -----------------------------------------------------------------------
`define AHP_WORD_INT_STATUS 4'h9
`define AHP_BE_LO       2'h1
`define AHP_BE_HI       2'h2
`define AHP_BE_ALL      2'h3
`define AHP_FIFO_EMPTY  6'h00
`define AHP_PIN_RST     27'h7c00000
`define AHP_INT_RST     8'h00
`define AHP_DATA_RST    16'h0000

`endif

// >>> inc/ahp_pkg.sv
/*
 * types shared by the host port files.
 * assumes ahp_cfg.svh is on the include path.
 */
`include "ahp_cfg.svh"

package ahp_pkg;

    // -------------------------------------------------------------------
    // access to the core registers, fifo and instruction ram
    // -------------------------------------------------------------------
    typedef struct packed {
        logic                     rd;
        logic                     wr;
        logic [`AHP_WORD_W-1:0]   word;
        logic [1:0]               be;
        logic [`AHP_DATA_W-1:0]   wdata;
    } ahp_req_t;

    // -------------------------------------------------------------------
    // synchronised host strobes
    // -------------------------------------------------------------------
    typedef struct packed {
        logic rd_b;
        logic wr_b;
        logic cs_b;
        logic ale;
    } ahp_strobe_t;

    typedef enum logic [1:0] {
        AHP_IDLE,
        AHP_READ,
        AHP_WRITE
    } ahp_acc_t;

endpackage

// >>> rtl/ahp_pin_sync.sv
/*
 * two-flop synchroniser for a vector of pins, with rising-edge pulses.
 * assumes the pins are asynchronous to clk.
 */
module ahp_pin_sync #(
    parameter int             W   = 1,
    parameter logic [W-1:0]   RST = '0
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] level,
    output logic      [W-1:0] rise
);

    logic [W-1:0] meta_q;
    logic [W-1:0] level_q;
    logic [W-1:0] prev_q;

    // -------------------------------------------------------------------
    // synchroniser, first stage read only by second
    // -------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            meta_q  <= RST;
            level_q <= RST;
            prev_q  <= RST;
        end
        else
        begin
            meta_q  <= pin_in;
            level_q <= meta_q;
            prev_q  <= level_q;
        end
    end

    assign level = level_q;
    assign rise  = level_q & ~prev_q;

endmodule

// >>> rtl/ahp_host_port.sv
/*
 * host-facing port of the acquisition device: bus access, sync pin,
 * interrupt output, dma request and channel select decode.
 * assumes a core on the same clock that answers register reads
 * combinationally and reports start and end of each operation.
 */
`include "ahp_cfg.svh"

// Operation
// - one external clock times all logic
// - five address lines select all storage
// - sync pin direction follows configuration bit
// - sync rise captures the input sample
// - next edge starts conversion or comparison
// - output sync high during each operation
// - reset makes sync pin an input
// - narrow bus: low lanes, upper lanes released
// - wide bus uses all sixteen lanes
// - unmasked interrupt source drives interrupt low
// - status read clears interrupt and releases
// - dma request rises at programmed fifo count
// - dma request falls only on empty
// - instruction picks single or differential channels
// - drive on read, capture on write
// - chip select low pauses the core
// - address latch strobe falling latches address
module ahp_host_port (
    input  wire logic                       clk,
    input  wire logic                       rst_b,
    input  wire logic [`AHP_ADDR_W-1:0]     register_address_lines,
    input  wire logic [`AHP_DATA_W-1:0]     host_data_lines_in,
    output logic      [`AHP_DATA_W-1:0]     host_data_lines_out,
    output logic      [`AHP_DATA_W-1:0]     host_data_lines_oe,
    input  wire logic                       rd_b,
    input  wire logic                       wr_b,
    input  wire logic                       cs_b,
    input  wire logic                       ale,
    input  wire logic                       bus_width_select,
    input  wire logic                       sync_pin_in,
    output logic                            sync_pin_out,
    output logic                            sync_pin_oe,
    output logic                            int_b,
    output logic                            dma_request_out,
    input  wire logic                       sync_dir,
    input  wire logic                       op_compare,
    input  wire logic                       op_started,
    input  wire logic                       op_done,
    output logic                            hold_capture,
    output logic                            start_convert,
    output logic                            start_compare,
    output logic                            core_run,
    output ahp_pkg::ahp_req_t               core_req,
    input  wire logic [`AHP_DATA_W-1:0]     core_rdata,
    input  wire logic [`AHP_INT_N-1:0]      int_source,
    input  wire logic [`AHP_INT_N-1:0]      int_enable,
    output logic      [`AHP_INT_N-1:0]      int_status,
    input  wire logic [`AHP_CNT_W-1:0]      fifo_count,
    input  wire logic [`AHP_CNT_W-1:0]      dma_count,
    input  wire logic [`AHP_CHAN_W-1:0]     instr_chan_pos,
    input  wire logic [`AHP_CHAN_W-1:0]     instr_chan_neg,
    input  wire logic                       instr_diff,
    output logic      [`AHP_CHAN_N-1:0]     chan_pos_sel,
    output logic      [`AHP_CHAN_N-1:0]     chan_neg_sel
);

    // -------------------------------------------------------------------
    // pin synchronisers
    // -------------------------------------------------------------------
    logic [`AHP_PIN_W-1:0]   pin_lvl;
    logic [`AHP_PIN_W-1:0]   pin_rise;
    ahp_pkg::ahp_strobe_t    stb;
    logic                    bw_s;
    logic                    sync_s_rise;
    logic [`AHP_ADDR_W-1:0]  addr_s;
    logic [`AHP_DATA_W-1:0]  din_s;

    ahp_pin_sync #(
        .W   (`AHP_PIN_W),
        .RST (`AHP_PIN_RST)
    ) u_sync (
        .clk    (clk),
        .rst_b  (rst_b),
        .pin_in ({rd_b, wr_b, cs_b, ale, bus_width_select, sync_pin_in,
                  register_address_lines, host_data_lines_in}),
        .level  (pin_lvl),
        .rise   (pin_rise)
    );

    assign stb         = pin_lvl[26:23];
    assign bw_s        = pin_lvl[22];
    assign sync_s_rise = pin_rise[21];
    assign addr_s      = pin_lvl[20:16];
    assign din_s       = pin_lvl[15:0];

    // -------------------------------------------------------------------
    // address and select latch
    // -------------------------------------------------------------------
    logic [`AHP_ADDR_W-1:0]  addr_q;
    logic                    sel_q;
    logic [`AHP_ADDR_W-1:0]  addr_eff;
    logic                    selected;
    logic                    rd_act;
    logic                    wr_act;

    // transparent while strobe high, frozen on its fall
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            addr_q <= '0;
            sel_q  <= 1'b0;
        end
        else if (stb.ale)
        begin
            addr_q <= addr_s;
            sel_q  <= ~stb.cs_b;
        end
    end

    assign addr_eff = stb.ale ? addr_s : addr_q;
    assign selected = stb.ale ? ~stb.cs_b : sel_q;
    assign rd_act   = selected & ~stb.rd_b;
    assign wr_act   = selected & ~stb.wr_b;

    // -------------------------------------------------------------------
    // access sequencer
    // -------------------------------------------------------------------
    ahp_pkg::ahp_acc_t       acc_q;
    ahp_pkg::ahp_req_t       req_q;
    logic [1:0]              be_d;
    logic                    stat_hit;

    // narrow bus: bit 0 picks the byte, wide bus: whole word
    assign be_d = !bw_s ? `AHP_BE_ALL :
                  (addr_eff[0] ? `AHP_BE_HI : `AHP_BE_LO);

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            acc_q <= ahp_pkg::AHP_IDLE;
            req_q <= '0;
        end
        else
        begin
            req_q.rd <= 1'b0;
            req_q.wr <= 1'b0;
            case (acc_q)
                ahp_pkg::AHP_IDLE:
                begin
                    req_q.word <= addr_eff[`AHP_ADDR_W-1:1];
                    req_q.be   <= be_d;
                    if (rd_act)
                    begin
                        req_q.rd <= 1'b1;
                        acc_q    <= ahp_pkg::AHP_READ;
                    end
                    else if (wr_act)
                    begin
                        acc_q <= ahp_pkg::AHP_WRITE;
                    end
                end
                ahp_pkg::AHP_READ:
                begin
                    if (!rd_act)
                    begin
                        acc_q <= ahp_pkg::AHP_IDLE;
                    end
                end
                ahp_pkg::AHP_WRITE:
                begin
                    if (wr_act)
                    begin
                        req_q.wdata <= bw_s ?
                            {2{din_s[`AHP_BYTE_W-1:0]}} : din_s;
                    end
                    else
                    begin
                        req_q.wr <= 1'b1;
                        acc_q    <= ahp_pkg::AHP_IDLE;
                    end
                end
                default:
                begin
                    acc_q <= ahp_pkg::AHP_IDLE;
                end
            endcase
        end
    end

    assign core_req = req_q;
    assign stat_hit = req_q.rd & (req_q.word == `AHP_WORD_INT_STATUS);

    // -------------------------------------------------------------------
    // read data and lane drive
    // -------------------------------------------------------------------
    logic [`AHP_DATA_W-1:0]  rword;
    logic [`AHP_DATA_W-1:0]  dout_q;
    logic [`AHP_INT_N-1:0]   stat_q;

    assign rword = stat_hit ? {{`AHP_BYTE_W{1'b0}}, stat_q} : core_rdata;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            dout_q <= `AHP_DATA_RST;
        end
        else if (req_q.rd)
        begin
            if (req_q.be == `AHP_BE_HI)
            begin
                dout_q <= {rword[15:8], rword[15:8]};
            end
            else
            begin
                dout_q <= rword;
            end
        end
    end

    assign host_data_lines_out = dout_q;
    assign host_data_lines_oe  =
        {{`AHP_BYTE_W{rd_act & ~bw_s}}, {`AHP_BYTE_W{rd_act}}};

    // -------------------------------------------------------------------
    // interrupt status, cleared by its read, set wins
    // -------------------------------------------------------------------
    logic                    int_b_q;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            stat_q  <= `AHP_INT_RST;
            int_b_q <= 1'b1;
        end
        else
        begin
            stat_q  <= (stat_hit ? `AHP_INT_RST : stat_q)
                       | int_source;
            int_b_q <= ~|(((stat_hit ? `AHP_INT_RST : stat_q)
                       | int_source) & int_enable);
        end
    end

    assign int_b      = int_b_q;
    assign int_status = stat_q;

    // -------------------------------------------------------------------
    // dma request
    // -------------------------------------------------------------------
    logic                    dma_q;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            dma_q <= 1'b0;
        end
        else if (fifo_count == dma_count && fifo_count != `AHP_FIFO_EMPTY)
        begin
            dma_q <= 1'b1;
        end
        else if (fifo_count == `AHP_FIFO_EMPTY)
        begin
            dma_q <= 1'b0;
        end
    end

    assign dma_request_out = dma_q;

    // -------------------------------------------------------------------
    // sync pin and external trigger
    // -------------------------------------------------------------------
    logic                    dir_q;
    logic                    sync_out_q;
    logic                    hold_q;
    logic                    pend_q;
    logic                    conv_q;
    logic                    comp_q;
    logic                    go;

    assign go = (hold_q | pend_q) & stb.cs_b;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            dir_q      <= 1'b0;
            sync_out_q <= 1'b0;
        end
        else
        begin
            dir_q <= sync_dir;
            if (op_started)
            begin
                sync_out_q <= 1'b1;
            end
            else if (op_done)
            begin
                sync_out_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            hold_q <= 1'b0;
            pend_q <= 1'b0;
            conv_q <= 1'b0;
            comp_q <= 1'b0;
        end
        else
        begin
            hold_q <= ~dir_q & sync_s_rise;
            pend_q <= (hold_q | pend_q) & ~go;
            conv_q <= go & ~op_compare;
            comp_q <= go & op_compare;
        end
    end

    assign sync_pin_oe   = dir_q;
    assign sync_pin_out  = sync_out_q;
    assign hold_capture  = hold_q;
    assign start_convert = conv_q;
    assign start_compare = comp_q;
    assign core_run      = stb.cs_b;

    // -------------------------------------------------------------------
    // channel select from the current instruction
    // -------------------------------------------------------------------
    logic [`AHP_CHAN_N-1:0]  pos_q;
    logic [`AHP_CHAN_N-1:0]  neg_q;

    for (genvar i = 0; i < `AHP_CHAN_N; i++)
    begin : g_chan
        always_ff @(posedge clk or negedge rst_b)
        begin
            if (!rst_b)
            begin
                pos_q[i] <= 1'b0;
                neg_q[i] <= 1'b0;
            end
            else
            begin
                pos_q[i] <= instr_chan_pos == `AHP_CHAN_W'(i);
                neg_q[i] <= instr_diff
                            & (instr_chan_neg == `AHP_CHAN_W'(i));
            end
        end
    end

    assign chan_pos_sel = pos_q;
    assign chan_neg_sel = neg_q;

endmodule

// >>> dv/ahp_host_port_chk.sv
/*
 * concurrent checks on the host port, bound to its ports.
 * assumes one clock and an async active-low reset.
 */
module ahp_host_port_chk (
    input wire logic              clk,
    input wire logic              rst_b,
    input wire logic              rd_b,
    input wire logic              cs_b,
    input wire logic              bus_width_select,
    input wire logic [15:0]       host_data_lines_oe,
    input wire logic              sync_dir,
    input wire logic              sync_pin_in,
    input wire logic              sync_pin_oe,
    input wire logic              sync_pin_out,
    input wire logic              op_started,
    input wire logic              op_done,
    input wire logic              hold_capture,
    input wire logic              int_b,
    input wire logic [7:0]        int_status,
    input wire logic [7:0]        int_enable,
    input wire logic [7:0]        int_source,
    input wire ahp_pkg::ahp_req_t core_req,
    input wire logic              dma_request_out,
    input wire logic [5:0]        fifo_count,
    input wire logic [5:0]        dma_count
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    // ------------------------------------------------------------------
    // steps of the sync and status behaviour
    // ------------------------------------------------------------------
    sequence s_trig_rise;
        !sync_pin_oe && $rose(sync_pin_in);
    endsequence
    sequence s_op_begin;
        sync_pin_oe && op_started;
    endsequence
    sequence s_status_read;
        core_req.rd && core_req.word == 4'h9;
    endsequence

    a_dir_follows: assert property (
        $past(rst_b) |-> sync_pin_oe == $past(sync_dir))
        else $error("sync direction wrong");
    a_upper_lanes_off: assert property (
        bus_width_select && $past(bus_width_select)
        && $past(bus_width_select, 2) |-> host_data_lines_oe[15:8] == 8'h00)
        else $error("upper lanes driven on narrow bus");
    a_lanes_need_read: assert property (
        |host_data_lines_oe |-> !$past(rd_b, 2) && !$past(cs_b, 2))
        else $error("lanes driven without read");
    a_dma_rise: assert property (
        fifo_count == dma_count && dma_count != 6'h00 |=> dma_request_out)
        else $error("dma request missing");
    a_dma_fall: assert property (
        $fell(dma_request_out) |-> $past(fifo_count) == 6'h00)
        else $error("dma request dropped early");
    a_int_follows: assert property (
        $past(rst_b) |-> int_b == !(|(int_status & $past(int_enable))))
        else $error("interrupt out wrong");
    a_status_clear: assert property (
        s_status_read |=> int_status == $past(int_source))
        else $error("status not cleared");
    a_trig_capture: assert property (
        s_trig_rise |-> ##[1:5] hold_capture)
        else $error("no capture on sync rise");
    a_sync_out_high: assert property (
        s_op_begin |=> sync_pin_out)
        else $error("sync out not raised");
    a_sync_out_low: assert property (
        sync_pin_oe && op_done |=> !sync_pin_out)
        else $error("sync out not lowered");
endmodule

// >>> dv/ahp_core_model.sv
/*
 * behavioural core on the far side: read answers and timed operations.
 * assumes the clock and reset of the host port.
 */
module ahp_core_model #(
    parameter int OP_LEN = 6
) (
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire ahp_pkg::ahp_req_t core_req,
    output logic [15:0]            core_rdata,
    input  wire logic              start_convert,
    input  wire logic              start_compare,
    input  wire logic              kick,
    output logic                   op_started,
    output logic                   op_done
);
    logic [15:0] junk_q;
    int          left_q;

    // valid only in the read pulse, noise otherwise
    assign core_rdata = core_req.rd ? {core_req.word, ~core_req.word,
        8'h3c ^ {4'h0, core_req.word}} : junk_q;

    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
            junk_q <= 16'h0000;
        else
            junk_q <= junk_q + 16'h9e37;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            op_started <= 1'b0;
            op_done    <= 1'b0;
            left_q     <= 0;
        end
        else
        begin
            op_started <= start_convert | start_compare | kick;
            op_done    <= left_q == 1;
            if (start_convert | start_compare | kick)
                left_q <= OP_LEN;
            else if (left_q != 0)
                left_q <= left_q - 1;
        end
    end
endmodule

// >>> dv/ahp_host_port_tb_top.sv
/*
 * self-checking bench: bus in both widths, interrupts, dma, sync, mux.
 * assumes package, rtl, core model and checker compiled first.
 */
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
    $display("BAD %0t got %h exp %h", $time, g, e); end end

module ahp_host_port_tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk = 1'b0;
    logic rst_b, rd_b, wr_b, cs_b, ale, bus_width_select, sync_dir, sync_tb;
    logic sync_pin_in, sync_pin_out, sync_pin_oe, int_b, dma_request_out;
    logic op_compare, op_started, op_done, hold_capture, start_convert;
    logic start_compare, core_run, kick, instr_diff;
    logic [4:0]  register_address_lines;
    logic [15:0] host_data_lines_in, host_data_lines_out, host_data_lines_oe;
    logic [15:0] hd_tb, core_rdata, d;
    logic [7:0]  int_source, int_enable, int_status;
    logic [7:0]  chan_pos_sel, chan_neg_sel;
    logic [5:0]  fifo_count, dma_count;
    logic [2:0]  instr_chan_pos, instr_chan_neg;
    logic [31:0] rnd;
    ahp_pkg::ahp_req_t core_req;
    int n_errors, comparisons, n_hold, n_conv, n_cmp, m_stat, m_dma, m_hold;

    // released lanes show the pin level of whoever drives
    assign host_data_lines_in = (host_data_lines_out & host_data_lines_oe)
        | (hd_tb & ~host_data_lines_oe);
    assign sync_pin_in = sync_pin_oe ? sync_pin_out : sync_tb;

    ahp_host_port uut (.clk, .rst_b, .register_address_lines,
        .host_data_lines_in, .host_data_lines_out, .host_data_lines_oe,
        .rd_b, .wr_b, .cs_b, .ale, .bus_width_select, .sync_pin_in,
        .sync_pin_out, .sync_pin_oe, .int_b, .dma_request_out, .sync_dir,
        .op_compare, .op_started, .op_done, .hold_capture, .start_convert,
        .start_compare, .core_run, .core_req, .core_rdata, .int_source,
        .int_enable, .int_status, .fifo_count, .dma_count, .instr_chan_pos,
        .instr_chan_neg, .instr_diff, .chan_pos_sel, .chan_neg_sel);
    ahp_core_model u_core (.clk, .rst_b, .core_req, .core_rdata,
        .start_convert, .start_compare, .kick, .op_started, .op_done);

    always #20 clk = ~clk;

    always @(posedge clk)
    begin
        if (hold_capture === 1'b1)
            n_hold++;
        if (start_convert === 1'b1)
            n_conv++;
        if (start_compare === 1'b1)
            n_cmp++;
    end

    // ------------------------------------------------------------------
    // helpers and bus cycles
    // ------------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [15:0] exp_rd(input logic [4:0] a);
        logic [15:0] w;
        w = (a[4:1] == 4'h9) ? {8'h00, m_stat[7:0]} :
            {a[4:1], ~a[4:1], 8'h3c ^ {4'h0, a[4:1]}};
        return bus_width_select ? {8'h00, a[0] ? w[15:8] : w[7:0]} : w;
    endfunction
    task automatic hread(input logic [4:0] a);
        register_address_lines <= a;
        cs_b <= 1'b0;
        rd_b <= 1'b0;
        cyc(7);
        d = host_data_lines_out;
        `CHK(host_data_lines_oe, {{8{!bus_width_select}}, 8'hff})
        rd_b <= 1'b1;
        cs_b <= 1'b1;
        if (a[4:1] == 4'h9)
            m_stat = 0;
        cyc(5);
        `CHK(host_data_lines_oe, 16'h0000)
    endtask
    task automatic hwrite(input logic [4:0] a, input logic [15:0] v);
        int k;
        logic [23:0] ex;
        ex = {2'b01, a[4:1], bus_width_select ? (a[0] ? 2'h2 : 2'h1) : 2'h3,
            bus_width_select ? {2{v[7:0]}} : v};
        register_address_lines <= a;
        hd_tb <= v;
        cs_b <= 1'b0;
        wr_b <= 1'b0;
        cyc(5);
        `CHK(core_run, 1'b0)
        wr_b <= 1'b1;
        k = 0;
        while (core_req.wr !== 1'b1 && k < 12)
        begin
            cyc(1);
            k++;
        end
        `CHK(core_req, ex)
        cs_b <= 1'b1;
        hd_tb <= ~v;
        cyc(5);
        `CHK(core_run, 1'b1)
    endtask
    task automatic pulse(input logic [7:0] v);
        int_source <= v;
        cyc(1);
        int_source <= 8'h00;
        cyc(3);
        m_stat |= v;
    endtask
    task automatic give_verdict();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        rst_b = 1'b0;
        {rd_b, wr_b, cs_b, ale, sync_dir} = 5'h1f;
        {bus_width_select, sync_tb, op_compare, kick, instr_diff} = 5'h00;
        {register_address_lines, hd_tb, int_source, int_enable} = 37'h0;
        {fifo_count, dma_count, instr_chan_pos, instr_chan_neg} = 18'h0;
        rnd = 32'h4c915848;
        cyc(5);
        `CHK({int_b, dma_request_out, sync_pin_oe}, 3'b100)
        cyc(5);
        rst_b <= 1'b1;
        sync_dir <= 1'b0;
        cyc(4);
        for (int i = 0; i < 64; i++)
        begin
            bus_width_select <= i[5];
            rnd = lfsr(rnd);
            cyc(3);
            hwrite(i[4:0], rnd[15:0]);
            hread(i[4:0]);
            `CHK({bus_width_select ? 8'h00 : d[15:8], d[7:0]},
                exp_rd(i[4:0]))
        end
        bus_width_select <= 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            int_enable <= 8'h01 << i;
            pulse(~(8'h01 << i));
            `CHK({int_b, int_status}, {1'b1, m_stat[7:0]})
            pulse(8'h01 << i);
            `CHK({int_b, int_status}, {1'b0, m_stat[7:0]})
            hread(5'h12);
            `CHK({int_b, int_status}, 9'h100)
        end
        register_address_lines <= 5'h0a;
        cs_b <= 1'b0;
        cyc(3);
        ale <= 1'b0;
        cyc(3);
        hread(5'h04);
        `CHK(d, exp_rd(5'h0a))
        ale <= 1'b1;
        dma_count <= 6'h03;
        for (int i = 0; i < 40; i++)
        begin
            rnd = lfsr(rnd);
            fifo_count <= {3'h0, rnd[2:0]};
            cyc(3);
            m_dma = (rnd[2:0] == 3) ? 1 : (rnd[2:0] == 0) ? 0 : m_dma;
            `CHK(dma_request_out, m_dma[0])
        end
        for (int i = 0; i < 16; i++)
        begin
            rnd = lfsr(rnd);
            {instr_diff, instr_chan_pos, instr_chan_neg} <= rnd[6:0];
            cyc(3);
            `CHK(chan_pos_sel, 8'h01 << rnd[5:3])
            `CHK(chan_neg_sel, rnd[6] ? 8'h01 << rnd[2:0] : 8'h00)
        end
        for (int i = 0; i < 3; i++)
        begin
            op_compare <= i[0];
            cs_b <= i != 2;
            m_hold = n_hold + 1;
            sync_tb <= 1'b1;
            cyc(6);
            sync_tb <= 1'b0;
            cyc(6);
            `CHK(n_hold, m_hold)
            `CHK(n_conv + n_cmp, i + (i != 2))
            cs_b <= 1'b1;
            cyc(6);
            `CHK({n_conv, n_cmp}, {i / 2 + 1, (i > 0) ? 1 : 0})
        end
        sync_dir <= 1'b1;
        cyc(8);
        kick <= 1'b1;
        cyc(1);
        kick <= 1'b0;
        cyc(4);
        `CHK({sync_pin_oe, sync_pin_out}, 2'b11)
        cyc(10);
        `CHK({sync_pin_oe, sync_pin_out}, 2'b10)
        sync_dir <= 1'b0;
        cyc(3);
        `CHK(sync_pin_oe, 1'b0)
        give_verdict();
    end

    initial
    begin
        cyc(6000);
        n_errors++;
        give_verdict();
    end
endmodule

bind ahp_host_port ahp_host_port_chk u_chk (.clk, .rst_b, .rd_b, .cs_b,
    .bus_width_select, .host_data_lines_oe, .sync_dir, .sync_pin_in,
    .sync_pin_oe, .sync_pin_out, .op_started, .op_done, .hold_capture,
    .int_b, .int_status, .int_enable, .int_source, .core_req,
    .dma_request_out, .fifo_count, .dma_count);
